// [rtl/lane_shifter.sv]
// Serial data lane: word placement, send on falling and capture on rising bit clock
`timescale 1ns/100ps
`include "sap_map.svh"
module lane_shifter (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             en,
  // Synchronised link events
  input  wire logic             bit_fall,
  input  wire logic             bit_rise,
  input  wire logic             frame_lvl,
  input  wire logic             sdi,
  // Framing
  input  wire sap_pkg::fmt_e    tx_fmt,
  input  wire sap_pkg::fmt_e    rx_fmt,
  input  wire logic [5:0]       tx_wlen,
  input  wire logic [5:0]       rx_wlen,
  // Words
  input  wire logic [31:0]      tx_left,
  input  wire logic [31:0]      tx_right,
  output logic                  sdo_q,
  output logic      [31:0]      rx_word_q,
  output logic                  rx_left_q,
  output logic                  rx_strobe_q
);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !en);

  logic [5:0]  pos_q;
  logic [31:0] tx_sh_q;
  logic [31:0] rx_sh_q;
  logic        lr_last_q;
  logic        seen_q;
  // Frame level before the first falling edge is unknown, so that edge only arms
  logic        armed_q;

  function automatic logic in_win(input logic [5:0] p, input sap_pkg::fmt_e f,
                                  input logic [5:0] w);
    logic [6:0] start;
    start = (f == sap_pkg::FMT_LJ)  ? 7'h00 :
            (f == sap_pkg::FMT_I2S) ? 7'h01 : `HALF_BITS - {1'b0, w};
    return ({1'b0, p} >= start) && ({1'b0, p} < start + {1'b0, w})
           && (f != sap_pkg::FMT_BAD);
  endfunction

  // ==========================================================
  // Position within the half-frame
  wire        edge_w     = bit_fall && armed_q && (frame_lvl != lr_last_q);
  wire [5:0]  pos_d      = edge_w ? 6'h00 : (pos_q == 6'h3F) ? pos_q : pos_q + 6'h01;
  wire        tx_i2s_w   = (tx_fmt == sap_pkg::FMT_I2S);
  wire        rx_i2s_w   = (rx_fmt == sap_pkg::FMT_I2S);
  wire        left_now_w = tx_i2s_w ? !frame_lvl : frame_lvl;
  wire [31:0] tx_pick_w  = left_now_w ? tx_left : tx_right;
  wire [31:0] tx_align_w = tx_pick_w << (6'h20 - tx_wlen);
  wire [31:0] tx_cur_w   = edge_w ? tx_align_w : tx_sh_q;
  wire        tx_win_w   = in_win(pos_d, tx_fmt, tx_wlen);
  wire        rx_win_w   = in_win(pos_q, rx_fmt, rx_wlen);
  wire [31:0] rx_mask_w  = ~(32'hFFFF_FFFF << rx_wlen);

  // ==========================================================
  // Send: new bit only after a falling edge, MSB first
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !en) begin
      pos_q     <= 6'h00;
      lr_last_q <= 1'b0;
      armed_q   <= 1'b0;
      tx_sh_q   <= 32'h0000_0000;
      sdo_q     <= 1'b0;
    end else if (bit_fall) begin
      pos_q     <= pos_d;
      lr_last_q <= frame_lvl;
      armed_q   <= 1'b1;
      tx_sh_q   <= tx_win_w ? tx_cur_w << 1 : tx_cur_w;
      sdo_q     <= tx_win_w && tx_cur_w[31];
    end
  end

  // ==========================================================
  // Capture on rising edge; word closes at the frame clock edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !en) begin
      rx_sh_q     <= 32'h0000_0000;
      rx_word_q   <= 32'h0000_0000;
      rx_left_q   <= 1'b0;
      rx_strobe_q <= 1'b0;
      seen_q      <= 1'b0;
    end else begin
      rx_strobe_q <= edge_w && seen_q;
      if (bit_rise && rx_win_w) rx_sh_q <= {rx_sh_q[30:0], sdi};
      if (edge_w) begin
        seen_q    <= 1'b1;
        rx_sh_q   <= 32'h0000_0000;
        rx_word_q <= rx_sh_q & rx_mask_w;
        rx_left_q <= rx_i2s_w ? !lr_last_q : lr_last_q;
      end
    end
  end

  // ==========================================================
  // Checks
  AST_HALF_32: assert property (edge_w && seen_q |-> pos_q == `HALF_LAST)
    else $error("half-frame not 32 bit periods");
  AST_LJ_MSB_AT_EDGE: assert property (edge_w && tx_fmt == sap_pkg::FMT_LJ
    |=> sdo_q == $past(tx_align_w[31]))
    else $error("left-justified MSB not at frame edge");
  AST_I2S_DELAY: assert property (edge_w && tx_i2s_w |=> !sdo_q)
    else $error("I2S slot after frame edge not empty");
  AST_RJ_LEAD: assert property (bit_fall && tx_fmt == sap_pkg::FMT_RJ
    && pos_d < 6'h20 - tx_wlen |=> !sdo_q)
    else $error("right-justified lead bits not zero");
  AST_SDO_HOLD: assert property (!bit_fall |=> $stable(sdo_q))
    else $error("serial out changed off the falling edge");
  AST_CHAN_POL: assert property (edge_w && seen_q |=> rx_strobe_q
    && rx_left_q == (rx_i2s_w ? $past(frame_lvl) : !$past(frame_lvl)))
    else $error("received channel polarity wrong");

endmodule

// [rtl/sap_host.sv]
// Host controller for a serial audio port: link partner and command sequencer
`timescale 1ns/100ps
`include "sap_map.svh"
module sap_host (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial audio link
  input  wire logic        link_bit_clk,
  input  wire logic        link_frame_clk,
  input  wire logic        serial_out_lane0,
  output logic             serial_in_lane0,
  // Device command port
  output logic             ctl_cmd_valid,
  output logic      [2:0]  ctl_cmd_code,
  output logic      [15:0] ctl_cmd_data,
  input  wire logic        ctl_cmd_done
);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // State
  logic [3:0]     sync1_q;
  logic [3:0]     sync2_q;
  logic           bclk_d3_q;
  logic           wait_q;
  logic [31:0]    rdata_q;
  logic [16:0]    ctrl_pend_q;
  logic [16:0]    ctrl_act_q;
  logic [31:0]    tx_left_q;
  logic [31:0]    tx_right_q;
  logic [31:0]    rx_left_word_q;
  logic [31:0]    rx_right_word_q;
  logic           rx_new_q;
  logic           refused_q;
  logic           cfg_done_q;
  logic           muted_q;
  logic           recfg_done_q;
  sap_pkg::seq_e  seq_q;
  sap_pkg::op_t   op_q;
  logic [15:0]    data_q;
  logic           valid_q;
  logic           recfg_q;
  logic           sdo_w;
  logic [31:0]    rx_word_w;
  logic           rx_left_w;
  logic           rx_strobe_w;

  function automatic logic is_tone(input sap_pkg::op_t op);
    return (op == `OP_VOLUME) || (op == `OP_TREBLE) || (op == `OP_BASS);
  endfunction

  // ==========================================================
  // Link synchronisers: bit clock, frame clock, data, done
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q   <= 4'h0;
      sync2_q   <= 4'h0;
      bclk_d3_q <= 1'b0;
    end else begin
      sync1_q   <= {ctl_cmd_done, serial_out_lane0, link_frame_clk, link_bit_clk};
      sync2_q   <= sync1_q;
      bclk_d3_q <= sync2_q[0];
    end
  end

  wire bit_rise_w = sync2_q[0] && !bclk_d3_q;
  wire bit_fall_w = !sync2_q[0] && bclk_d3_q;
  wire done_s_w   = sync2_q[3];

  // ==========================================================
  // Avalon-MM: one wait cycle on every access
  wire acc_w  = (avs_read || avs_write) && wait_q;
  wire wr_w   = avs_write && !wait_q;
  wire [31:0] wdata_w = avs_writedata;

  wire sap_pkg::fmt_e tx_fmt_w = sap_pkg::fmt_decode(ctrl_act_q[`CTRL_TX_FMT]);
  wire sap_pkg::fmt_e rx_fmt_w = sap_pkg::fmt_decode(ctrl_act_q[`CTRL_RX_FMT]);
  wire [5:0] tx_wlen_w = sap_pkg::word_len(ctrl_act_q[`CTRL_TX_WS]);
  wire [5:0] rx_wlen_w = sap_pkg::word_len(ctrl_act_q[`CTRL_RX_WS]);
  wire fmt_bad_w = (tx_fmt_w == sap_pkg::FMT_BAD) || (rx_fmt_w == sap_pkg::FMT_BAD);
  wire busy_w    = (seq_q != sap_pkg::ST_IDLE);

  wire [5:0] status_w = {fmt_bad_w, muted_q, refused_q, busy_w, cfg_done_q, rx_new_q};

  wire [31:0] rd_mux_w =
    (avs_address == `REG_CTRL)     ? {15'h0000, ctrl_pend_q} :
    (avs_address == `REG_TX_LEFT)  ? tx_left_q :
    (avs_address == `REG_TX_RIGHT) ? tx_right_q :
    (avs_address == `REG_RX_LEFT)  ? rx_left_word_q :
    (avs_address == `REG_RX_RIGHT) ? rx_right_word_q :
    (avs_address == `REG_STATUS)   ? {26'h000_0000, status_w} :
    32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !acc_w;
      if (acc_w && avs_read) rdata_q <= rd_mux_w;
    end
  end

  // ==========================================================
  // Software-written registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_pend_q <= `CTRL_RESET;
      tx_left_q   <= 32'h0000_0000;
      tx_right_q  <= 32'h0000_0000;
    end else if (wr_w) begin
      if (avs_address == `REG_CTRL) ctrl_pend_q <= wdata_w[16:0];
      if (avs_address == `REG_TX_LEFT) tx_left_q <= wdata_w;
      if (avs_address == `REG_TX_RIGHT) tx_right_q <= wdata_w;
    end
  end

  // ==========================================================
  // Received words and sticky flags; a set wins over a clear
  wire st_wr_w  = wr_w && (avs_address == `REG_STATUS);
  wire clr_rx_w = st_wr_w && wdata_w[`ST_RX_NEW];
  wire clr_rf_w = st_wr_w && wdata_w[`ST_REFUSED];

  wire cmd_wr_w = wr_w && (avs_address == `REG_CMD);
  wire sap_pkg::op_t cmd_op_w = wdata_w[`CMD_OP];
  wire refuse_w = cmd_wr_w && (busy_w || (cmd_op_w > `OP_LAST)
                  || (is_tone(cmd_op_w) && !cfg_done_q));
  wire start_w  = cmd_wr_w && !refuse_w;
  wire recfg_w  = (cmd_op_w == `OP_RECONFIG);
  wire ack_w    = (seq_q == sap_pkg::ST_ACK) && done_s_w;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_left_word_q  <= 32'h0000_0000;
      rx_right_word_q <= 32'h0000_0000;
      rx_new_q        <= 1'b0;
      refused_q       <= 1'b0;
    end else begin
      if (rx_strobe_w && rx_left_w) rx_left_word_q <= rx_word_w;
      if (rx_strobe_w && !rx_left_w) rx_right_word_q <= rx_word_w;
      rx_new_q  <= rx_strobe_w || (rx_new_q && !clr_rx_w);
      refused_q <= refuse_w || (refused_q && !clr_rf_w);
    end
  end

  // ==========================================================
  // Completion tracking of device commands
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_done_q   <= 1'b0;
      muted_q      <= 1'b0;
      recfg_done_q <= 1'b0;
      ctrl_act_q   <= `CTRL_RESET;
    end else begin
      if (ack_w && op_q == `OP_CLOCK_CFG) cfg_done_q <= 1'b1;
      if (ack_w && op_q == `OP_MUTE) muted_q <= 1'b1;
      if (ack_w && op_q == `OP_UNMUTE) muted_q <= 1'b0;
      if (start_w) recfg_done_q <= 1'b0;
      if (ack_w && op_q == `OP_RECONFIG) begin
        recfg_done_q <= 1'b1;
        ctrl_act_q   <= ctrl_pend_q;
      end
    end
  end

  // ==========================================================
  // Sequencer: valid held until done, then done must fall.
  // Reconfiguration runs mute, reconfigure, unmute in that order.
  wire sap_pkg::op_t next_op_w = (op_q == `OP_MUTE) ? `OP_RECONFIG : `OP_UNMUTE;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seq_q   <= sap_pkg::ST_IDLE;
      op_q    <= `OP_CLOCK_CFG;
      data_q  <= 16'h0000;
      valid_q <= 1'b0;
      recfg_q <= 1'b0;
    end else begin
      unique case (seq_q)
        sap_pkg::ST_IDLE: if (start_w) begin
          recfg_q <= recfg_w;
          op_q    <= recfg_w ? `OP_MUTE : cmd_op_w;
          data_q  <= wdata_w[`CMD_DATA];
          valid_q <= 1'b1;
          seq_q   <= sap_pkg::ST_ACK;
        end
        sap_pkg::ST_ACK: if (done_s_w) begin
          valid_q <= 1'b0;
          seq_q   <= sap_pkg::ST_REL;
        end
        sap_pkg::ST_REL: if (!done_s_w) begin
          if (recfg_q && op_q != `OP_UNMUTE) begin
            op_q    <= next_op_w;
            data_q  <= (op_q == `OP_MUTE) ? ctrl_pend_q[15:0] : data_q;
            valid_q <= 1'b1;
            seq_q   <= sap_pkg::ST_ACK;
          end else begin
            recfg_q <= 1'b0;
            seq_q   <= sap_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Data lane
  lane_shifter u_lane (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .en          (ctrl_pend_q[`CTRL_EN]),
    .bit_fall    (bit_fall_w),
    .bit_rise    (bit_rise_w),
    .frame_lvl   (sync2_q[1]),
    .sdi         (sync2_q[2]),
    .tx_fmt      (tx_fmt_w),
    .rx_fmt      (rx_fmt_w),
    .tx_wlen     (tx_wlen_w),
    .rx_wlen     (rx_wlen_w),
    .tx_left     (tx_left_q),
    .tx_right    (tx_right_q),
    .sdo_q       (sdo_w),
    .rx_word_q   (rx_word_w),
    .rx_left_q   (rx_left_w),
    .rx_strobe_q (rx_strobe_w)
  );

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign serial_in_lane0 = sdo_w;
  assign ctl_cmd_valid   = valid_q;
  assign ctl_cmd_code    = op_q;
  assign ctl_cmd_data    = data_q;

  // ==========================================================
  // Checks
  AST_CFG_FIRST: assert property (valid_q && is_tone(op_q) |-> cfg_done_q)
    else $error("tone command before clock configuration");
  AST_TONE_REFUSED: assert property (cmd_wr_w && is_tone(cmd_op_w) && !cfg_done_q
    |=> refused_q && !$rose(valid_q))
    else $error("early tone command not refused");
  AST_MUTE_BEFORE_RECFG: assert property ($rose(valid_q) && op_q == `OP_RECONFIG
    |-> muted_q && !done_s_w && $past(seq_q) == sap_pkg::ST_REL)
    else $error("reconfigure before mute completed");
  AST_UNMUTE_AFTER_RECFG: assert property ($rose(valid_q) && op_q == `OP_UNMUTE
    && recfg_q |-> recfg_done_q && !done_s_w)
    else $error("unmute before reconfiguration completed");
  AST_BUS_ONE_WAIT: assert property (acc_w |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  AST_RD_STABLE: assert property (!(acc_w && avs_read) |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  // ==========================================================
  // Command handshake: a step is held until done, raised only while done is low
  AST_CMD_HOLD: assert property (valid_q && !done_s_w
    |=> valid_q && $stable(op_q) && $stable(data_q))
    else $error("command dropped or changed before done");
  AST_VALID_DROP: assert property (valid_q && done_s_w |=> !valid_q)
    else $error("command held after done");
  AST_RAISE_DONE_LOW: assert property ($rose(valid_q) |-> !done_s_w)
    else $error("command raised while done still high");
  AST_ACT_AT_ACK: assert property (!(ack_w && op_q == `OP_RECONFIG)
    |=> $stable(ctrl_act_q))
    else $error("framing changed outside a reconfigure acknowledge");
  AST_CFG_STICKY: assert property (cfg_done_q |=> cfg_done_q)
    else $error("clock configuration flag lost");

endmodule

// [rtl/sap_map.svh]
// Offsets, fields, codes and widths of the serial audio host controller
`ifndef SAP_MAP_SVH
`define SAP_MAP_SVH

// ==========================================================
// Register word addresses (Avalon word address)
`define REG_CTRL      3'h0
`define REG_TX_LEFT   3'h1
`define REG_TX_RIGHT  3'h2
`define REG_RX_LEFT   3'h3
`define REG_RX_RIGHT  3'h4
`define REG_STATUS    3'h5
`define REG_CMD       3'h6

// ==========================================================
// CTRL fields
`define CTRL_TX_FMT   3:0
`define CTRL_TX_WS    5:4
`define CTRL_RX_FMT   11:8
`define CTRL_RX_WS    13:12
`define CTRL_EN       16
`define CTRL_RESET    17'h0_0000

// ==========================================================
// STATUS bits
`define ST_RX_NEW     0
`define ST_CFG_DONE   1
`define ST_BUSY       2
`define ST_REFUSED    3
`define ST_MUTED      4
`define ST_FMT_BAD    5

// ==========================================================
// CMD fields and operation codes
`define CMD_OP        18:16
`define CMD_DATA      15:0
`define OP_CLOCK_CFG  3'h0
`define OP_VOLUME     3'h1
`define OP_TREBLE     3'h2
`define OP_BASS       3'h3
`define OP_MUTE       3'h4
`define OP_UNMUTE     3'h5
`define OP_RECONFIG   3'h6
`define OP_LAST       3'h6

// ==========================================================
// Framing codes, word lengths, half-frame size
`define FMT_CODE_LJ   4'h0
`define FMT_CODE_RJ   4'h1
`define FMT_CODE_I2S  4'h2
`define WLEN_32       6'h20
`define WLEN_16       6'h10
`define WLEN_20       6'h14
`define WLEN_24       6'h18
`define HALF_BITS     7'h20
`define HALF_LAST     6'h1F

`endif

// [rtl/sap_pkg.sv]
// Types and decode functions of the serial audio host controller
`include "sap_map.svh"
package sap_pkg;

  typedef enum logic [1:0] {FMT_LJ, FMT_RJ, FMT_I2S, FMT_BAD} fmt_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_REL} seq_e;
  typedef logic [2:0] op_t;

  // Only the two-channel framings are carried by this host
  function automatic fmt_e fmt_decode(input logic [3:0] code);
    fmt_e f;
    f = FMT_BAD;
    if (code == `FMT_CODE_LJ) f = FMT_LJ;
    if (code == `FMT_CODE_RJ) f = FMT_RJ;
    if (code == `FMT_CODE_I2S) f = FMT_I2S;
    return f;
  endfunction

  function automatic logic [5:0] word_len(input logic [1:0] code);
    logic [5:0] w;
    w = `WLEN_32;
    if (code == 2'h1) w = `WLEN_16;
    if (code == 2'h2) w = `WLEN_20;
    if (code == 2'h3) w = `WLEN_24;
    return w;
  endfunction

endpackage

// [testbench/audio_dev_model.sv]
// Behavioural audio device on the far side of the serial link and command port
`timescale 1ns/100ps
module audio_dev_model (
  // Host clock
  input  wire logic          clk_sys,
  // Serial link
  output logic               link_bit_clk,
  output logic               link_frame_clk,
  output logic               serial_out_lane0,
  input  wire logic          serial_in_lane0,
  // Command port
  input  wire logic          ctl_cmd_valid,
  input  wire logic [2:0]    ctl_cmd_code,
  input  wire logic [15:0]   ctl_cmd_data,
  output logic               ctl_cmd_done,
  // Bench controls
  input  wire sap_pkg::fmt_e fmt,
  input  wire logic [5:0]    wlen,
  input  wire logic          slow,
  // Fixed device words: any sample latency leaves the link unchanged
  input  wire logic [31:0]   dev_left,
  input  wire logic [31:0]   dev_right,
  output logic      [31:0]   got_left,
  output logic      [31:0]   got_right
);
  logic [5:0]  pos;
  logic [31:0] shreg;
  logic        cfg_seen;
  logic [2:0]  op_q[$];
  logic [15:0] dat_q[$];
  int          errs;

  // ==========================================================
  // Word placement: bit index of a half-frame slot, -1 outside
  function automatic int slot(input logic [4:0] i, input sap_pkg::fmt_e f, input int w);
    int k;
    k = (f == sap_pkg::FMT_RJ) ? i - (32 - w) : (f == sap_pkg::FMT_I2S) ? i - 1 : i;
    return (k >= 0 && k < w) ? w - 1 - k : -1;
  endfunction

  // Free-running bit clock, phase unrelated to the host clock
  initial begin
    link_bit_clk = 1'b0;
    link_frame_clk = 1'b0;
    serial_out_lane0 = 1'b0;
    pos = 6'h3F;
    shreg = 32'h0;
    got_left = 32'h0;
    got_right = 32'h0;
    #137;
    forever #400 link_bit_clk = ~link_bit_clk;
  end

  always @(negedge link_bit_clk) begin : launch
    int b;
    pos = pos + 6'h01;
    b = slot(pos[4:0], fmt, wlen);
    link_frame_clk <= (fmt == sap_pkg::FMT_I2S) ? pos[5] : ~pos[5];
    // Unused slots toggle, so a host that fails to mask them is caught
    serial_out_lane0 <= (b < 0) ? ~serial_out_lane0 :
                        (pos[5] ? dev_right[b] : dev_left[b]);
  end

  always @(posedge link_bit_clk) begin : capture
    int b;
    b = slot(pos[4:0], fmt, wlen);
    if (b >= 0)
      shreg[b] = serial_in_lane0;
    if (pos[4:0] == 5'h1F) begin
      if (pos[5])
        got_right <= shreg;
      else
        got_left <= shreg;
      shreg = 32'h0;
    end
  end

  // ==========================================================
  // Command port: four-phase acknowledge, prompt or slow
  initial begin
    ctl_cmd_done = 1'b0;
    cfg_seen = 1'b0;
    errs = 0;
    forever begin
      wait (ctl_cmd_valid === 1'b1);
      if (ctl_cmd_code inside {3'h1, 3'h2, 3'h3} && !cfg_seen) errs++;
      if (ctl_cmd_code == 3'h6 && (op_q.size() == 0 || op_q[$] != 3'h4)) errs++;
      if (ctl_cmd_code == 3'h5 && (op_q.size() == 0 || op_q[$] != 3'h6)) errs++;
      cfg_seen |= (ctl_cmd_code == 3'h0);
      op_q.push_back(ctl_cmd_code);
      dat_q.push_back(ctl_cmd_data);
      repeat (slow ? 40 : 2) @(posedge clk_sys);
      ctl_cmd_done <= 1'b1;
      wait (ctl_cmd_valid === 1'b0);
      repeat (slow ? 25 : 1) @(posedge clk_sys);
      ctl_cmd_done <= 1'b0;
      @(posedge clk_sys);
    end
  end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench of the serial audio host controller
`timescale 1ns/100ps
`include "sap_map.svh"
module tb_top;
  localparam logic [31:0] DEV_L = 32'hA5C3_9E71;
  localparam logic [31:0] DEV_R = 32'h5E1F_0C3B;
  localparam logic [31:0] TX_L  = 32'h9D2B_47E6;
  localparam logic [31:0] TX_R  = 32'h36F8_B15D;

  logic          clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [2:0]    avs_address, cmd_code;
  logic [31:0]   avs_writedata, avs_readdata, got_l, got_r, rd;
  logic          bclk, fclk, dev_sdo, host_sdo, cmd_valid, cmd_done, slow;
  logic [15:0]   cmd_data;
  logic [5:0]    wlen;
  sap_pkg::fmt_e fmt;
  int            miscompares, tests_run;

  sap_host u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_bit_clk(bclk),
    .link_frame_clk(fclk), .serial_out_lane0(dev_sdo), .serial_in_lane0(host_sdo),
    .ctl_cmd_valid(cmd_valid), .ctl_cmd_code(cmd_code), .ctl_cmd_data(cmd_data),
    .ctl_cmd_done(cmd_done));

  audio_dev_model u_dev (.clk_sys(clk_sys), .link_bit_clk(bclk), .link_frame_clk(fclk),
    .serial_out_lane0(dev_sdo), .serial_in_lane0(host_sdo), .ctl_cmd_valid(cmd_valid),
    .ctl_cmd_code(cmd_code), .ctl_cmd_data(cmd_data), .ctl_cmd_done(cmd_done), .fmt(fmt),
    .wlen(wlen), .slow(slow), .dev_left(DEV_L), .dev_right(DEV_R), .got_left(got_l),
    .got_right(got_r));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    check(n, 32'h2, "one wait cycle");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp, input string what);
    av(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask

  task automatic cmd(input logic [2:0] op, input logic [15:0] d);
    av(1'b1, `REG_CMD, {13'h0, op, d});
    do begin
      av(1'b0, `REG_STATUS, 32'h0);
    end while (rd[`ST_BUSY] !== 1'b0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    check({31'h0, cmd_valid}, 32'h0, "command idle");
    check({31'h0, host_sdo}, 32'h0, "lane idle");
    rd_chk(`REG_CTRL, 32'h0, "ctrl reset");
    rd_chk(`REG_STATUS, 32'h0, "status reset");
    av(1'b1, 3'h7, 32'hFFFF_FFFF);
    rd_chk(3'h7, 32'h0, "unmapped");
    rd_chk(`REG_CMD, 32'h0, "cmd reads zero");
    $display("test reset done");
  endtask

  task automatic t_order;
    int i;
    cmd(`OP_VOLUME, 16'h00AB);
    rd_chk(`REG_STATUS, 32'h8, "early volume refused");
    check(u_dev.op_q.size(), 32'h0, "nothing sent early");
    av(1'b1, `REG_STATUS, 32'h8);
    rd_chk(`REG_STATUS, 32'h0, "refused cleared");
    cmd(`OP_CLOCK_CFG, 16'h1234);
    for (i = 1; i < 4; i++)
      cmd(3'(i), 16'(i));
    rd_chk(`REG_STATUS, 32'h2, "clock cfg done");
    for (i = 0; i < 4; i++)
      check(u_dev.op_q[i], i, "command order");
    $display("test command order done");
  endtask

  task automatic t_fmt(input logic [3:0] code, input sap_pkg::fmt_e f, input logic [1:0] ws,
                       input logic [5:0] w, input logic s);
    logic [31:0] m, ctrl;
    m = 32'hFFFF_FFFF >> (32 - w);
    ctrl = {15'h0, 1'b1, 2'h0, ws, code, 2'h0, ws, code};
    slow <= s;
    u_dev.op_q.delete();
    u_dev.dat_q.delete();
    // Lane held off while the frame clock polarity may flip
    av(1'b1, `REG_CTRL, ctrl & 32'hFFFE_FFFF);
    fmt <= f;
    wlen <= w;
    cmd(`OP_RECONFIG, 16'h0055);
    check(u_dev.op_q.size(), 32'h3, "reconfig steps");
    check(u_dev.op_q[0], `OP_MUTE, "mute first");
    check(u_dev.op_q[1], `OP_RECONFIG, "reconfig second");
    check(u_dev.dat_q[1], ctrl[15:0], "reconfig data");
    check(u_dev.op_q[2], `OP_UNMUTE, "unmute last");
    check(u_dev.dat_q[0], 32'h0055, "mute data");
    check(u_dev.dat_q[2], ctrl[15:0], "unmute data");
    av(1'b1, `REG_CTRL, ctrl);
    // Four frames of 64 bit clocks
    repeat (2100) @(posedge clk_sys);
    rd_chk(`REG_RX_LEFT, DEV_L & m, "rx left");
    rd_chk(`REG_RX_RIGHT, DEV_R & m, "rx right");
    check(got_l, TX_L & m, "tx left");
    check(got_r, TX_R & m, "tx right");
    av(1'b0, `REG_STATUS, 32'h0);
    check(rd & 32'h31, 32'h1, "rx new, unmuted, format ok");
    $display("test format %0h size %0h done", code, ws);
  endtask

  task automatic t_bad;
    av(1'b1, `REG_CTRL, 32'h0001_0303);
    cmd(`OP_RECONFIG, 16'h0000);
    av(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, rd[`ST_FMT_BAD]}, 32'h1, "multichannel code flagged");
    $display("test unsupported format done");
  endtask

  // ==========================================================
  // Sequence, watchdog and verdict
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    miscompares = 0;
    tests_run = 0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    slow = 1'b0;
    fmt = sap_pkg::FMT_LJ;
    wlen = `WLEN_32;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_order();
    av(1'b1, `REG_TX_LEFT, TX_L);
    av(1'b1, `REG_TX_RIGHT, TX_R);
    t_fmt(`FMT_CODE_LJ, sap_pkg::FMT_LJ, 2'h0, `WLEN_32, 1'b0);
    t_fmt(`FMT_CODE_RJ, sap_pkg::FMT_RJ, 2'h1, `WLEN_16, 1'b1);
    t_fmt(`FMT_CODE_I2S, sap_pkg::FMT_I2S, 2'h3, `WLEN_24, 1'b0);
    t_fmt(`FMT_CODE_LJ, sap_pkg::FMT_LJ, 2'h2, `WLEN_20, 1'b1);
    t_fmt(`FMT_CODE_RJ, sap_pkg::FMT_RJ, 2'h3, `WLEN_24, 1'b0);
    t_bad();
    check(u_dev.errs, 32'h0, "device saw no order fault");
    print_verdict();
  end

  // Tests need about 1.1 ms
  initial begin
    #5_000_000;
    miscompares++;
    print_verdict();
  end
endmodule
